//--- verilog/ftsc_pkg.sv
// Function
// - Act on clock edges only while gate low.
// - Gate high stretches the current operation.
// - Sleep request idles device, keeps memory.
// - Input data captured on rising clock edge.
// - Read data from address of preceding edge.
// - Output enable low drives data and parity.
// - Float data and parity during write data.
// - Float first cycle after leaving deselect.
// - Float while deselected by chip selects.
// - Parity behaves exactly like data lines.
// - Strap low linear, high interleaved burst.
// - Read starts when selected, write high, load.
// - Two-bit burst counter wraps after four.
// - Advance steps counter, keeps latched access type.
package ftsc_pkg;

  // Array organisation: 512K words of 32 data and 4 parity bits.
  localparam int ADDR_W = 19;
  localparam int DATA_W = 32;
  localparam int PAR_W = 4;
  // One byte lane carries eight data bits and one parity bit.
  localparam int BYTE_W = 8;
  // Width of the burst counter and of the address bits that it replaces.
  localparam int BURST_W = 2;
  // Depth of the synchronisers on asynchronous pins.
  localparam int SYNC_STAGES = 2;

  // Strap level that selects the linear burst order.
  localparam logic STRAP_LINEAR = 1'h0;
  // Strap reset value: a floating strap means interleaved order.
  localparam logic STRAP_RESET = 1'h1;
  // Output enable pin reset value: not driving.
  localparam logic DRIVE_N_RESET = 1'h1;
  // Sleep pin reset value: awake.
  localparam logic SLEEP_RESET = 1'h0;
  // First burst count after a load.
  localparam logic [BURST_W-1:0] COUNT_START = 2'h0;
  // Step of the burst counter.
  localparam logic [BURST_W-1:0] COUNT_STEP = 2'h1;

  // Access phase of the device, one-hot.
  typedef enum logic [2:0] {
    FTSC_DESEL = 3'h1,
    FTSC_READ = 3'h2,
    FTSC_WRITE = 3'h4
  } ftsc_phase_t;

  // Synchronous control pins sampled together on each edge.
  typedef struct packed {
    logic selected;
    logic write;
    logic advance;
  } ftsc_cmd_t;

  // Burst position: start offset and steps taken since the load.
  typedef struct packed {
    logic [BURST_W-1:0] start;
    logic [BURST_W-1:0] count;
  } ftsc_burst_t;

endpackage

//--- verilog/ftsc_mem.sv
`timescale 1ns/1ps
// Storage array with per-lane write enables and a registered read port.
module ftsc_mem #(
  parameter int ADDR_W = 19,
  parameter int LANES = 4,
  parameter int LANE_W = 9
) (
  // Clock.
  input wire logic clk,
  // Read port; data come out of a register.
  input wire logic rd_en,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [LANES*LANE_W-1:0] rd_data,
  // Write port with one enable per lane.
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [LANES-1:0] wr_lane_en,
  input wire logic [LANES*LANE_W-1:0] wr_data
);

  // The array itself has no reset, like the real cells.
  logic [LANES*LANE_W-1:0] mem [2**ADDR_W];

  // Refuse shapes the lane logic cannot serve.
  if (ADDR_W < 2 || LANES < 1 || LANE_W < 1) begin : g_check
    $error("ftsc_mem: bad geometry");
  end

  // Write selected lanes only; unselected lanes keep their contents.
  always_ff @(posedge clk) begin
    if (wr_en) begin
      for (int i = 0; i < LANES; i++) begin
        if (wr_lane_en[i]) begin
          mem[wr_addr][i*LANE_W +: LANE_W] <= wr_data[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  // Registered read; the word holds while no read is requested.
  always_ff @(posedge clk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

//--- verilog/ftsc_io_ctrl.sv
`timescale 1ns/1ps
// Flow-through burst memory: pin behaviour, burst counter and drive control.
module ftsc_io_ctrl #(
  parameter int ADDR_W = ftsc_pkg::ADDR_W,
  parameter int DATA_W = ftsc_pkg::DATA_W,
  parameter int PAR_W = ftsc_pkg::PAR_W
) (
  // Clock and synchronous reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Clock qualification and sleep.
  input wire logic clock_gate_n,
  input wire logic sleep_request,
  // Chip selects.
  input wire logic chip_select_first_n,
  input wire logic chip_select_second,
  input wire logic chip_select_third_n,
  // Access control.
  input wire logic write_select_n,
  input wire logic advance_or_load,
  input wire logic [ADDR_W-1:0] address,
  input wire logic [PAR_W-1:0] byte_write_n,
  // Asynchronous output enable and burst order strap.
  input wire logic output_drive_enable_n,
  input wire logic burst_mode_strap,
  // Data lines split into input, output and enable.
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  // Parity lines split the same way.
  input wire logic [PAR_W-1:0] parity_in,
  output logic [PAR_W-1:0] parity_out,
  output logic parity_oe
);

  localparam int BYTE_W = ftsc_pkg::BYTE_W;
  localparam int LANE_W = ftsc_pkg::BYTE_W + 1;
  localparam int BW = ftsc_pkg::BURST_W;

  // Every parity bit guards one byte, so the lanes must line up.
  // The burst offset replaces the low bits, so some upper bits must remain.
  if (DATA_W != PAR_W * ftsc_pkg::BYTE_W || ADDR_W <= BW) begin : g_check
    $error("ftsc_io_ctrl: data, parity and address widths do not match");
  end

  // Synchroniser chains for the asynchronous pins.
  logic [ftsc_pkg::SYNC_STAGES-1:0] sleep_sync_q, sleep_sync_d;
  logic [ftsc_pkg::SYNC_STAGES-1:0] drive_sync_q, drive_sync_d;
  logic [ftsc_pkg::SYNC_STAGES-1:0] strap_sync_q, strap_sync_d;
  // Synchronised levels; only the last stage is ever read.
  logic asleep;
  logic drive_n;
  logic linear;

  // Access state.
  ftsc_pkg::ftsc_phase_t phase_q, phase_d;
  ftsc_pkg::ftsc_burst_t burst_q, burst_d;
  logic [ADDR_W-1:0] base_q, base_d;
  logic first_q, first_d;
  // Pending write: address and lanes wait for the data edge.
  logic wr_pend_q, wr_pend_d;
  logic [ADDR_W-1:0] wr_addr_q, wr_addr_d;
  logic [PAR_W-1:0] wr_lane_q, wr_lane_d;

  // Qualified edge and sampled commands.
  logic edge_ok;
  ftsc_pkg::ftsc_cmd_t cmd;
  logic [BW-1:0] offset;
  logic [ADDR_W-1:0] next_addr;
  logic rd_en;
  // Word packing between pins and lanes.
  logic [PAR_W*LANE_W-1:0] wr_word;
  logic [PAR_W*LANE_W-1:0] rd_word;
  logic drive;

  // Asynchronous pins each pass two flip-flops before use.
  always_comb begin
    sleep_sync_d = {sleep_sync_q[ftsc_pkg::SYNC_STAGES-2:0], sleep_request};
    drive_sync_d = {drive_sync_q[ftsc_pkg::SYNC_STAGES-2:0], output_drive_enable_n};
    strap_sync_d = {strap_sync_q[ftsc_pkg::SYNC_STAGES-2:0], burst_mode_strap};
  end

  // Synchroniser registers, preset to the safe idle levels.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sleep_sync_q <= {ftsc_pkg::SYNC_STAGES{ftsc_pkg::SLEEP_RESET}};
      drive_sync_q <= {ftsc_pkg::SYNC_STAGES{ftsc_pkg::DRIVE_N_RESET}};
      strap_sync_q <= {ftsc_pkg::SYNC_STAGES{ftsc_pkg::STRAP_RESET}};
    end else begin
      sleep_sync_q <= sleep_sync_d;
      drive_sync_q <= drive_sync_d;
      strap_sync_q <= strap_sync_d;
    end
  end

  assign asleep = sleep_sync_q[ftsc_pkg::SYNC_STAGES-1];
  assign drive_n = drive_sync_q[ftsc_pkg::SYNC_STAGES-1];
  // A floating strap reads high and so gives the interleaved order.
  assign linear = (strap_sync_q[ftsc_pkg::SYNC_STAGES-1] == ftsc_pkg::STRAP_LINEAR);

  // The clock counts only while the gate pin is low.
  assign edge_ok = !clock_gate_n;

  // Decode the synchronous control pins for this edge.
  always_comb begin
    cmd.selected = !chip_select_first_n && chip_select_second && !chip_select_third_n;
    cmd.write = !write_select_n;
    cmd.advance = advance_or_load;
  end

  // Next access state. A stretched edge holds everything, so a gate pulse
  // never deselects the part; it only lengthens the cycle in progress.
  always_comb begin
    phase_d = phase_q;
    burst_d = burst_q;
    base_d = base_q;
    first_d = first_q;
    wr_pend_d = wr_pend_q;
    wr_addr_d = wr_addr_q;
    wr_lane_d = wr_lane_q;
    if (edge_ok) begin
      // The data phase of a pending write ends on this edge.
      wr_pend_d = 1'b0;
      first_d = 1'b0;
      if (cmd.advance) begin
        // Advance ignores selects and write pin; the burst keeps its type.
        if (phase_q != ftsc_pkg::FTSC_DESEL) begin
          burst_d.count = burst_q.count + ftsc_pkg::COUNT_STEP;
        end
      end else if (cmd.selected && !asleep) begin
        // A load latches the address and the access type.
        base_d = address;
        burst_d.start = address[BW-1:0];
        burst_d.count = ftsc_pkg::COUNT_START;
        if (cmd.write) begin
          phase_d = ftsc_pkg::FTSC_WRITE;
        end else begin
          phase_d = ftsc_pkg::FTSC_READ;
        end
        first_d = (phase_q == ftsc_pkg::FTSC_DESEL);
      end else begin
        // Deselect, or a new request turned away while asleep.
        phase_d = ftsc_pkg::FTSC_DESEL;
      end
    end
    // Each write step books its address and lanes for the next edge.
    if (edge_ok && phase_d == ftsc_pkg::FTSC_WRITE) begin
      wr_pend_d = 1'b1;
      wr_addr_d = next_addr;
      wr_lane_d = ~byte_write_n;
    end
  end

  // Burst offset: linear adds the count, interleaved flips start bits.
  always_comb begin
    if (linear) begin
      offset = burst_d.start + burst_d.count;
    end else begin
      offset = burst_d.start ^ burst_d.count;
    end
    next_addr = {base_d[ADDR_W-1:BW], offset};
  end

  // Access state registers.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      phase_q <= ftsc_pkg::FTSC_DESEL;
      burst_q <= '0;
      base_q <= '0;
      first_q <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      wr_lane_q <= '0;
    end else begin
      phase_q <= phase_d;
      burst_q <= burst_d;
      base_q <= base_d;
      first_q <= first_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      wr_lane_q <= wr_lane_d;
    end
  end

  // The read fetches on the edge that samples its address, so the word
  // is on the pins during the very next cycle: flow-through timing.
  assign rd_en = edge_ok && phase_d == ftsc_pkg::FTSC_READ;

  // Pack pins into lanes of one byte plus its parity bit.
  always_comb begin
    wr_word = '0;
    for (int i = 0; i < PAR_W; i++) begin
      wr_word[i*LANE_W +: LANE_W] = {parity_in[i], data_in[i*BYTE_W +: BYTE_W]};
    end
  end

  // Array; the write port samples the pins on the data edge, which is
  // the input data register of the part.
  ftsc_mem #(
    .ADDR_W(ADDR_W),
    .LANES(PAR_W),
    .LANE_W(LANE_W)
  ) u_mem (
    .clk(core_clk),
    .rd_en(rd_en),
    .rd_addr(next_addr),
    .rd_data(rd_word),
    .wr_en(edge_ok && wr_pend_q),
    .wr_addr(wr_addr_q),
    .wr_lane_en(wr_lane_q),
    .wr_data(wr_word)
  );

  // Unpack the registered read word onto the pins.
  always_comb begin
    data_out = '0;
    parity_out = '0;
    for (int i = 0; i < PAR_W; i++) begin
      {parity_out[i], data_out[i*BYTE_W +: BYTE_W]} = rd_word[i*LANE_W +: LANE_W];
    end
  end

  // Drive only during a read, never during write data, deselect, the
  // first cycle out of deselect or sleep. The enable pin is synchronised,
  // so it acts two cycles late; a real pad would gate it directly.
  always_comb begin
    drive = !drive_n;
    if (phase_q != ftsc_pkg::FTSC_READ) begin
      drive = 1'b0;
    end else if (first_q || asleep) begin
      drive = 1'b0;
    end
  end

  // Parity follows data exactly.
  assign data_oe = drive;
  assign parity_oe = drive;

endmodule

//--- verification/ftsc_io_ctrl_asserts.sv
`timescale 1ns/1ps
// Pin-level checks of the burst memory block.
module ftsc_io_ctrl_asserts #(
  parameter int DATA_W = 32
) (
  // Clock, reset and qualifiers.
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clock_gate_n,
  input wire logic sleep_request,
  // Selects and access control.
  input wire logic chip_select_first_n,
  input wire logic chip_select_second,
  input wire logic chip_select_third_n,
  input wire logic write_select_n,
  input wire logic advance_or_load,
  input wire logic output_drive_enable_n,
  // Outputs watched.
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe,
  input wire logic parity_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Decoded requests on qualified edges.
  logic sel, ld, adv, rd_ld, wr_ld;
  assign sel = !chip_select_first_n && chip_select_second && !chip_select_third_n;
  assign ld = !clock_gate_n && !advance_or_load;
  assign adv = !clock_gate_n && advance_or_load;
  assign rd_ld = ld && sel && write_select_n;
  assign wr_ld = ld && sel && !write_select_n;
  // Enable low, awake and clock counted: the conditions for a driven read.
  logic awake_on;
  assign awake_on = !output_drive_enable_n && !sleep_request && !clock_gate_n;
  a_gate_hold: assert property (clock_gate_n |=> $stable(data_out))
    else $error("read data changed on a gated edge");
  a_parity_same: assert property (parity_oe == data_oe)
    else $error("parity drive differs from data drive");
  a_desel_float: assert property (ld && !sel |=> !data_oe)
    else $error("driving while deselected");
  a_write_float: assert property (wr_ld |=> !data_oe)
    else $error("driving in write data phase");
  a_burst_type: assert property (wr_ld ##1 adv |=> !data_oe)
    else $error("write burst lost its access type");
  a_first_read: assert property (ld && !sel ##1 rd_ld |=> !data_oe)
    else $error("driving first cycle after deselect");
  a_enable_off: assert property ((output_drive_enable_n && !clock_gate_n)[*3] |-> !data_oe)
    else $error("driving with enable high");
  a_sleep_off: assert property ((sleep_request && !clock_gate_n)[*3] |-> !data_oe)
    else $error("driving while asleep");
  a_read_drive: assert property (awake_on[*3] ##0 rd_ld ##1 rd_ld |=> data_oe)
    else $error("read data not driven");
endmodule
bind ftsc_io_ctrl ftsc_io_ctrl_asserts #(.DATA_W(DATA_W)) u_chk (
  .core_clk(core_clk),
  .resetn(resetn),
  .clock_gate_n(clock_gate_n),
  .sleep_request(sleep_request),
  .chip_select_first_n(chip_select_first_n),
  .chip_select_second(chip_select_second),
  .chip_select_third_n(chip_select_third_n),
  .write_select_n(write_select_n),
  .advance_or_load(advance_or_load),
  .output_drive_enable_n(output_drive_enable_n),
  .data_out(data_out),
  .data_oe(data_oe),
  .parity_oe(parity_oe)
);

//--- verification/ftsc_ctl_model.sv
`timescale 1ns/1ps
// Controller side of the shared data and parity wires.
module ftsc_ctl_model (
  // Clock.
  input wire logic core_clk,
  // Drive flag in the top bit, then parity and data.
  input wire logic [36:0] req,
  // Memory side of the wires.
  input wire logic oe,
  input wire logic [35:0] q,
  // Resolved wire level.
  output logic [31:0] data_in,
  output logic [3:0] parity_in
);
  // A released wire toggles so stale data never match by chance.
  logic [35:0] last_q = 36'h0;
  always_ff @(posedge core_clk) begin
    last_q <= req[36] ? req[35:0] : ~last_q;
  end
  assign {parity_in, data_in} = req[36] ? req[35:0] : (oe ? q : last_q);
endmodule

//--- verification/test_flow_through_sram_io_control.sv
`timescale 1ns/1ps
// Drives the block as its memory controller would and checks the pins.
module test_flow_through_sram_io_control;
  // Command codes: {gate_n, selected, write_n, advance}.
  localparam logic [3:0] RD = 4'h6, WR = 4'h4, AV = 4'h1, DS = 4'h2, GT = 4'h9;
  logic core_clk = 1'h0;
  logic resetn = 1'h0;
  logic gn = 1'h0, slp = 1'h0, s1n = 1'h1, s2 = 1'h0, s3n = 1'h1;
  logic wen = 1'h1, adv = 1'h0, oen = 1'h0, strap = 1'h0;
  logic [18:0] addr = 19'h0;
  logic [3:0] bwn = 4'h0, pin, pout;
  logic [36:0] req = 37'h0;
  logic [31:0] din, dout;
  logic doe, poe;
  logic [35:0] exp_q [0:3];
  int miscompares = 0;
  int check_count = 0;
  ftsc_io_ctrl dut (.core_clk(core_clk), .resetn(resetn), .clock_gate_n(gn),
    .sleep_request(slp), .chip_select_first_n(s1n), .chip_select_second(s2),
    .chip_select_third_n(s3n), .write_select_n(wen), .advance_or_load(adv), .address(addr),
    .byte_write_n(bwn), .output_drive_enable_n(oen), .burst_mode_strap(strap),
    .data_in(din), .data_out(dout), .data_oe(doe), .parity_in(pin), .parity_out(pout),
    .parity_oe(poe));
  ftsc_ctl_model ctl (.core_clk(core_clk), .req(req), .oe(doe), .q({pout, dout}),
    .data_in(din), .parity_in(pin));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [35:0] got, input logic [35:0] want);
    check_count++;
    if (got !== want) begin
      miscompares++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask
  // One cycle; on return the pins show the previous cycle's request.
  task automatic cyc(input logic [3:0] c, input logic [18:0] a, input logic [36:0] d);
    @(posedge core_clk);
    gn <= c[3];
    s1n <= !c[2];
    s2 <= c[2];
    s3n <= !c[2];
    wen <= c[1];
    adv <= c[0];
    addr <= a;
    req <= d;
    #1;
  endtask
  // Two reads of location zero, then a check of the second.
  task automatic rd2(input logic want_oe);
    for (int i = 0; i < 3; i++) cyc(i < 2 ? RD : DS, 19'h100, 37'h0);
    chk({pout, dout}, exp_q[0]);
    chk(doe, want_oe);
  endtask
  task automatic t_wr_lin();
    logic [35:0] v;
    cyc(WR, 19'h101, 37'h0);
    for (int i = 0; i < 4; i++) begin
      v = 36'h5_a5a5_a500 + 36'(i) * 36'h1_0101_0101;
      exp_q[(i + 1) % 4] = v;
      cyc(i < 3 ? AV : DS, 19'h0, {1'h1, v});
      chk(doe, 1'h0);
    end
    $display("linear write burst done");
  endtask
  task automatic t_rd_int();
    @(posedge core_clk);
    strap <= 1'h1;
    repeat (3) cyc(DS, 19'h0, 37'h0);
    cyc(RD, 19'h102, 37'h0);
    for (int i = 0; i < 4; i++) begin
      cyc(i < 3 ? AV : DS, 19'h0, 37'h0);
      chk({pout, dout}, exp_q[2 ^ i]);
      chk(doe, i != 0);
    end
    $display("interleaved read burst done");
  endtask
  task automatic t_byte();
    @(posedge core_clk);
    bwn <= 4'h5;
    cyc(WR, 19'h100, 37'h0);
    cyc(DS, 19'h0, {1'h1, 36'hf_ffff_ffff});
    @(posedge core_clk);
    bwn <= 4'h0;
    exp_q[0] = (exp_q[0] & 36'h5_00ff_00ff) | 36'ha_ff00_ff00;
    rd2(1'h1);
    $display("byte write done");
  endtask
  task automatic t_gate();
    cyc(RD, 19'h100, 37'h0);
    cyc(RD, 19'h101, 37'h0);
    for (int i = 0; i < 5; i++) begin
      cyc(i < 3 ? GT : (i == 3 ? AV : DS), 19'h0, 37'h0);
      chk({pout, dout}, exp_q[i < 4 ? 1 : 0]);
      chk(doe, 1'h1);
    end
    $display("clock gate done");
  endtask
  task automatic t_oe_sleep();
    @(posedge core_clk);
    oen <= 1'h1;
    rd2(1'h0);
    @(posedge core_clk);
    oen <= 1'h0;
    cyc(RD, 19'h100, 37'h0);
    cyc(RD, 19'h100, 37'h0);
    @(posedge core_clk);
    slp <= 1'h1;
    // Sleep seen in mid-burst must float the lines two edges later.
    for (int i = 0; i < 3; i++) begin
      cyc(AV, 19'h0, 37'h0);
      chk(doe, i == 0);
    end
    repeat (3) cyc(DS, 19'h0, 37'h0);
    cyc(WR, 19'h100, 37'h0);
    cyc(RD, 19'h100, 37'h1_0000_0000_0);
    cyc(DS, 19'h0, 37'h0);
    chk(doe, 1'h0);
    @(posedge core_clk);
    slp <= 1'h0;
    repeat (3) cyc(DS, 19'h0, 37'h0);
    rd2(1'h1);
    $display("enable and sleep done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'h1;
    repeat (3) cyc(DS, 19'h0, 37'h0);
    t_wr_lin();
    t_rd_int();
    t_byte();
    t_gate();
    t_oe_sleep();
    test_done();
  end
  // Cuts a hang short well after the tests' 63 cycles.
  initial begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    test_done();
  end
endmodule
